// File: rtl/umu_top.sv
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module umu_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // instruction word stream
  input  wire logic [15:0] word_i,
  input  wire logic        word_valid_i,
  output logic             word_ready_o,
  // register file read
  output logic             rf_rd_req_o,
  output logic      [3:0]  rf_rd_addr_o,
  output logic      [1:0]  rf_rd_size_o,
  input  wire logic        rf_rd_ack_i,
  input  wire logic [63:0] rf_rd_data_i,
  // memory operand fetch
  output logic             mem_req_o,
  output logic             mem_eam_o,
  output logic      [3:0]  mem_field_o,
  output logic             mem_long_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_data_i,
  // destination write back
  output logic             wr_en_o,
  output logic      [3:0]  wr_addr_o,
  output logic             wr_long_o,
  output logic      [63:0] wr_data_o,
  output logic      [7:0]  flags_o
);
  import umu_pkg::*;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic        ack_q;
  logic [31:0] dat_q;
  logic        en_q;
  logic [7:0]  flags_q;
  logic [63:0] prod_q;
  logic        bus_wr;

  assign bus_wr = cyc_i && stb_i && we_i && ack_q && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end

  // unmapped offsets read zero and still ack, so a master never hangs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (cyc_i && stb_i && !ack_q) begin
      if (adr_i == ADR_CTRL) begin
        dat_q <= {31'h0, en_q};
      end else if (adr_i == ADR_FLAGS) begin
        dat_q <= {24'h0, flags_q};
      end else if (adr_i == ADR_PROD_LO) begin
        dat_q <= prod_q[31:0];
      end else if (adr_i == ADR_PROD_HI) begin
        dat_q <= prod_q[63:32];
      end else begin
        dat_q <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= CTRL_RST;
    end else if (bus_wr && adr_i == ADR_CTRL) begin
      en_q <= dat_i[0];
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  umu_state_t  state_q;
  umu_state_t  state_d;
  logic        long_q;
  logic [1:0]  mode_q;
  logic [3:0]  src_q;
  logic [3:0]  dst_q;
  logic [31:0] srcv_q;
  logic [31:0] dstv_q;
  logic        take;
  logic [1:0]  w_mode;
  logic [5:0]  w_opc;
  logic [3:0]  w_src;
  logic        w_ok;

  assign take   = word_valid_i && word_ready_o;
  assign w_mode = word_i[15:14];
  assign w_opc  = word_i[13:8];
  assign w_src  = word_i[7:4];
  assign w_ok   = (w_opc == OPC_WORD || w_opc == OPC_LONG) && w_mode != 2'h3;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (take && word_i == PREFIX_WORD) begin
          state_d = S_OPC;
        end
      end
      S_OPC: begin
        if (take) begin
          if (!w_ok) begin
            state_d = S_IDLE;
          end else if (w_mode == MODE_REG) begin
            state_d = S_RD_SRC;
          end else if (w_mode == MODE_IM_IR && w_src == FIELD_IMM) begin
            state_d = (w_opc == OPC_LONG) ? S_IMM_HI : S_IMM_LO;
          end else begin
            state_d = S_MEM;
          end
        end
      end
      S_IMM_HI: begin
        if (take) begin
          state_d = S_IMM_LO;
        end
      end
      S_IMM_LO: begin
        if (take) begin
          state_d = S_RD_DST;
        end
      end
      S_RD_SRC: begin
        if (rf_rd_ack_i) begin
          state_d = S_RD_DST;
        end
      end
      S_MEM: begin
        if (mem_ack_i) begin
          state_d = S_RD_DST;
        end
      end
      S_RD_DST: begin
        if (rf_rd_ack_i) begin
          state_d = S_EXEC;
        end
      end
      S_EXEC:  state_d = S_WRITE;
      S_WRITE: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // decoded fields of the opcode word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      long_q <= 1'b0;
      mode_q <= 2'h0;
      src_q  <= 4'h0;
      dst_q  <= 4'h0;
    end else if (state_q == S_OPC && take) begin
      long_q <= (w_opc == OPC_LONG);
      mode_q <= w_mode;
      src_q  <= w_src;
      dst_q  <= word_i[3:0];
    end
  end

  // source operand, zero extended whatever its origin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srcv_q <= 32'h0;
    end else if (state_q == S_OPC && take) begin
      srcv_q <= 32'h0;
    end else if (state_q == S_IMM_HI && take) begin
      srcv_q[31:16] <= word_i;
    end else if (state_q == S_IMM_LO && take) begin
      srcv_q[15:0] <= word_i;
    end else if (state_q == S_RD_SRC && rf_rd_ack_i) begin
      srcv_q <= long_q ? rf_rd_data_i[31:0] : {16'h0, rf_rd_data_i[15:0]};
    end else if (state_q == S_MEM && mem_ack_i) begin
      srcv_q <= long_q ? mem_data_i : {16'h0, mem_data_i[15:0]};
    end
  end

  // upper half of the destination is never captured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dstv_q <= 32'h0;
    end else if (state_q == S_RD_DST && rf_rd_ack_i) begin
      dstv_q <= long_q ? rf_rd_data_i[31:0] : {16'h0, rf_rd_data_i[15:0]};
    end
  end

  // ------------------------------------------------------------
  // operand requests toward the core
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_ready_o <= 1'b0;
      rf_rd_req_o  <= 1'b0;
      rf_rd_addr_o <= 4'h0;
      rf_rd_size_o <= SIZE_WORD;
      mem_req_o    <= 1'b0;
      mem_eam_o    <= 1'b0;
      mem_field_o  <= 4'h0;
      mem_long_o   <= 1'b0;
    end else begin
      word_ready_o <= en_q && (state_d == S_IDLE || state_d == S_OPC ||
                               state_d == S_IMM_HI || state_d == S_IMM_LO);
      rf_rd_req_o  <= (state_d == S_RD_SRC || state_d == S_RD_DST);
      if (state_d == S_RD_SRC) begin
        rf_rd_addr_o <= (state_q == S_OPC) ? w_src : src_q;
        // word_i is stale once the opcode word is gone, so hold the latched size
        rf_rd_size_o <= ((state_q == S_OPC) ? (w_opc == OPC_LONG) : long_q) ?
                        SIZE_PAIR : SIZE_WORD;
      end else if (state_d == S_RD_DST) begin
        rf_rd_addr_o <= dst_q;
        rf_rd_size_o <= long_q ? SIZE_QUAD : SIZE_PAIR;
      end
      mem_req_o <= (state_d == S_MEM);
      if (state_q == S_OPC && take) begin
        mem_eam_o   <= (w_mode == MODE_EAM);
        mem_field_o <= w_src;
        mem_long_o  <= (w_opc == OPC_LONG);
      end
    end
  end

  // ------------------------------------------------------------
  // multiply and write back
  // ------------------------------------------------------------
  logic [63:0] prod_full;
  logic        carry;
  logic        zero;
  logic        sign;

  assign prod_full = {32'h0, dstv_q} * {32'h0, srcv_q};
  assign carry     = long_q ? (prod_q[63:32] != 32'h0) : (prod_q[31:16] != 16'h0);
  assign zero      = long_q ? (prod_q == 64'h0) : (prod_q[31:0] == 32'h0);
  assign sign      = long_q ? prod_q[63] : prod_q[31];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prod_q <= 64'h0;
    end else if (state_q == S_EXEC) begin
      prod_q <= long_q ? prod_full : {32'h0, prod_full[31:0]};
    end
  end

  // only the destination address is ever written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_en_o   <= 1'b0;
      wr_addr_o <= 4'h0;
      wr_long_o <= 1'b0;
      wr_data_o <= 64'h0;
    end else begin
      wr_en_o <= (state_q == S_EXEC);
      if (state_q == S_EXEC) begin
        wr_addr_o <= dst_q;
        wr_long_o <= long_q;
        wr_data_o <= long_q ? prod_full : {32'h0, prod_full[31:0]};
      end
    end
  end

  // hardware flag update wins over a bus write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= FLAGS_RST;
    end else if (state_q == S_WRITE) begin
      flags_q[FLG_C] <= carry;
      flags_q[FLG_Z] <= zero;
      flags_q[FLG_S] <= sign;
      flags_q[FLG_V] <= 1'b0;
    end else if (bus_wr && adr_i == ADR_FLAGS) begin
      flags_q <= dat_i[7:0];
    end
  end

  assign flags_o = flags_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_prefix;
    state_q == S_IDLE && take && word_i == PREFIX_WORD;
  endsequence
  sequence seq_long_imm;
    state_q == S_OPC && take && w_opc == OPC_LONG && w_mode == MODE_IM_IR &&
      w_src == FIELD_IMM;
  endsequence

  a_prefix_decode: assert property (seq_prefix |=> state_q == S_OPC)
    else $error("prefix word did not open a decode");
  a_long_imm_order: assert property (seq_long_imm |=> state_q == S_IMM_HI)
    else $error("long immediate did not start with high word");
  a_reg_src_mode: assert property (state_q == S_OPC && take && w_ok && w_mode == MODE_REG
    |=> state_q == S_RD_SRC)
    else $error("register mode did not read source register");
  a_indirect_mode: assert property (state_q == S_OPC && take && w_ok &&
    w_mode == MODE_IM_IR && w_src != FIELD_IMM |=> state_q == S_MEM && !mem_eam_o)
    else $error("indirect mode not sent to memory fetch");
  a_word_product: assert property (state_q == S_EXEC && !long_q
    |=> wr_en_o && wr_data_o == {32'h0, 32'(dstv_q[15:0]) * 32'(srcv_q[15:0])})
    else $error("word product wrong");
  a_long_product: assert property (state_q == S_EXEC && long_q
    |=> wr_en_o && wr_data_o == {32'h0, dstv_q} * {32'h0, srcv_q})
    else $error("long product wrong");
  a_src_size: assert property (state_q == S_RD_SRC && rf_rd_req_o
    |-> rf_rd_size_o == (long_q ? SIZE_PAIR : SIZE_WORD))
    else $error("source read size wrong");
  a_dest_only: assert property (wr_en_o |-> wr_addr_o == dst_q)
    else $error("write aimed away from destination");
  a_carry_upper: assert property (state_q == S_WRITE ##1 !flags_q[FLG_C]
    |-> (wr_long_o ? wr_data_o[63:32] == 32'h0 : wr_data_o[31:16] == 16'h0))
    else $error("carry clear but upper half nonzero");
  a_zero_flag: assert property (state_q == S_WRITE |=> flags_q[FLG_Z] ==
    (wr_long_o ? wr_data_o == 64'h0 : wr_data_o[31:0] == 32'h0))
    else $error("zero flag disagrees with product");
  a_sign_flag: assert property (state_q == S_WRITE |=> flags_q[FLG_S] ==
    (wr_long_o ? wr_data_o[63] : wr_data_o[31]))
    else $error("sign flag disagrees with product");
  a_ovf_clear: assert property (state_q == S_WRITE |=> !flags_q[FLG_V] &&
    flags_q[7:4] == $past(flags_q[7:4]))
    else $error("overflow not cleared or other flags touched");
  a_carry_flag: assert property (state_q == S_WRITE |=> flags_q[FLG_C] ==
    (wr_long_o ? wr_data_o[63:32] != 32'h0 : wr_data_o[31:16] != 16'h0))
    else $error("carry flag wrong");
endmodule

// File: rtl/umu_pkg.sv
package umu_pkg;
  // ------------------------------------------------------------
  // instruction encoding
  // ------------------------------------------------------------
  localparam logic [15:0] PREFIX_WORD  = 16'h7A03;
  localparam logic [5:0]  OPC_WORD     = 6'h19;
  localparam logic [5:0]  OPC_LONG     = 6'h18;
  localparam logic [1:0]  MODE_REG     = 2'h2;
  localparam logic [1:0]  MODE_IM_IR   = 2'h0;
  localparam logic [1:0]  MODE_EAM     = 2'h1;
  localparam logic [3:0]  FIELD_IMM    = 4'h0;
  localparam logic [1:0]  SIZE_WORD    = 2'h0;
  localparam logic [1:0]  SIZE_PAIR    = 2'h1;
  localparam logic [1:0]  SIZE_QUAD    = 2'h2;
  // ------------------------------------------------------------
  // register map and reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_FLAGS    = 8'h04;
  localparam logic [7:0]  ADR_PROD_LO  = 8'h08;
  localparam logic [7:0]  ADR_PROD_HI  = 8'h0C;
  localparam logic        CTRL_RST     = 1'h1;
  localparam logic [7:0]  FLAGS_RST    = 8'h00;
  localparam int          FLG_C        = 0;
  localparam int          FLG_Z        = 1;
  localparam int          FLG_S        = 2;
  localparam int          FLG_V        = 3;
  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE   = 4'h0,
    S_OPC    = 4'h1,
    S_IMM_HI = 4'h2,
    S_IMM_LO = 4'h3,
    S_RD_SRC = 4'h4,
    S_MEM    = 4'h5,
    S_RD_DST = 4'h6,
    S_EXEC   = 4'h7,
    S_WRITE  = 4'h8
  } umu_state_t;
endpackage

// File: tb/umu_core_model.sv
`timescale 1ns/100ps
module umu_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic        rf_rd_req_i,
  input  wire logic [3:0]  rf_rd_addr_i,
  output logic             rf_rd_ack_o,
  output logic      [63:0] rf_rd_data_o,
  input  wire logic        mem_req_i,
  input  wire logic [3:0]  mem_field_i,
  output logic             mem_ack_o,
  output logic      [31:0] mem_data_o,
  input  wire logic        wr_en_i,
  input  wire logic [3:0]  wr_addr_i,
  input  wire logic        wr_long_i,
  input  wire logic [63:0] wr_data_i
);
  logic [63:0] regs    [16];
  logic [31:0] mem_val [16];
  logic [3:0]  rf_cnt_q;
  logic [3:0]  mem_cnt_q;
  // ------------------------------------------------------------
  // read answers
  // ------------------------------------------------------------
  // data inverts every idle cycle so a late capture cannot pass
  always @(posedge clk_i) begin
    if (rst_i) begin
      rf_rd_ack_o  <= 1'b0;
      rf_cnt_q     <= 4'h0;
      rf_rd_data_o <= 64'h0;
    end else if (rf_rd_req_i && !rf_rd_ack_o && rf_cnt_q >= delay_i) begin
      rf_rd_ack_o  <= 1'b1;
      rf_cnt_q     <= 4'h0;
      rf_rd_data_o <= regs[rf_rd_addr_i];
    end else begin
      rf_rd_ack_o  <= 1'b0;
      rf_cnt_q     <= (rf_rd_req_i && !rf_rd_ack_o) ? rf_cnt_q + 4'h1 : 4'h0;
      rf_rd_data_o <= ~rf_rd_data_o;
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_ack_o  <= 1'b0;
      mem_cnt_q  <= 4'h0;
      mem_data_o <= 32'h0;
    end else if (mem_req_i && !mem_ack_o && mem_cnt_q >= delay_i) begin
      mem_ack_o  <= 1'b1;
      mem_cnt_q  <= 4'h0;
      mem_data_o <= mem_val[mem_field_i];
    end else begin
      mem_ack_o  <= 1'b0;
      mem_cnt_q  <= (mem_req_i && !mem_ack_o) ? mem_cnt_q + 4'h1 : 4'h0;
      mem_data_o <= ~mem_data_o;
    end
  end
  // ------------------------------------------------------------
  // write back
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (wr_en_i && wr_long_i) regs[wr_addr_i] <= wr_data_i;
    else if (wr_en_i) regs[wr_addr_i][31:0] <= wr_data_i[31:0];
  end
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import umu_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, word_valid_i, word_ready_o;
  logic [7:0]  adr_i, flags_o;
  logic [3:0]  sel_i, rf_rd_addr_o, mem_field_o, wr_addr_o, lat;
  logic [31:0] dat_i, dat_o, mem_data_i, rd;
  logic [15:0] word_i;
  logic [1:0]  rf_rd_size_o;
  logic        rf_rd_req_o, rf_rd_ack_i, mem_req_o, mem_eam_o, mem_long_o, mem_ack_i;
  logic        wr_en_o, wr_long_o;
  logic [63:0] rf_rd_data_i, wr_data_o;
  int          mismatches, check_count;
  logic [3:0]  rf_sizes;
  logic [1:0]  mem_cap;
  // sizes of the last two register reads, and the last memory fetch kind
  always @(posedge clk_i) begin
    if (rf_rd_req_o && rf_rd_ack_i) rf_sizes <= {rf_sizes[1:0], rf_rd_size_o};
    if (mem_req_o && mem_ack_i) mem_cap <= {mem_eam_o, mem_long_o};
  end
  umu_top u_umu_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .word_i, .word_valid_i, .word_ready_o, .rf_rd_req_o, .rf_rd_addr_o, .rf_rd_size_o,
    .rf_rd_ack_i, .rf_rd_data_i, .mem_req_o, .mem_eam_o, .mem_field_o, .mem_long_o,
    .mem_ack_i, .mem_data_i, .wr_en_o, .wr_addr_o, .wr_long_o, .wr_data_o, .flags_o);
  umu_core_model u_umu_core_model (.clk_i, .rst_i, .delay_i(lat), .rf_rd_req_i(rf_rd_req_o),
    .rf_rd_addr_i(rf_rd_addr_o), .rf_rd_ack_o(rf_rd_ack_i), .rf_rd_data_o(rf_rd_data_i),
    .mem_req_i(mem_req_o), .mem_field_i(mem_field_o), .mem_ack_o(mem_ack_i),
    .mem_data_o(mem_data_i), .wr_en_i(wr_en_o), .wr_addr_i(wr_addr_o),
    .wr_long_i(wr_long_o), .wr_data_i(wr_data_o));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 50);
    chk(ack_o, 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic send(input logic [15:0] w);
    int k;
    k = 0;
    word_i       <= w;
    word_valid_i <= 1'b1;
    do begin @(posedge clk_i); k++; end while (word_ready_o !== 1'b1 && k < 100);
    chk(word_ready_o, 1'b1);
  endtask
  // multiplicand loaded with junk above the used half on purpose
  task automatic run(input logic [15:0] op, input int n, input logic [31:0] imm,
                     input logic [63:0] dv, input logic [63:0] sv, input logic [63:0] exp);
    logic lng;
    int   k;
    lng = (op[13:8] == OPC_LONG);
    lat <= lat ? 4'h0 : 4'h3;
    u_umu_core_model.regs[op[3:0]] = dv;
    if (op[15:14] == MODE_REG) u_umu_core_model.regs[op[7:4]] = sv;
    else u_umu_core_model.mem_val[op[7:4]] = sv[31:0];
    wb(1'b1, ADR_FLAGS, 32'hA8);
    send(PREFIX_WORD);
    send(op);
    if (n == 2) send(imm[31:16]);
    if (n > 0) send(imm[15:0]);
    word_valid_i <= 1'b0;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wr_en_o !== 1'b1 && k < 200);
    chk(wr_en_o, 1'b1);
    chk(wr_addr_o, op[3:0]);
    chk(wr_long_o, lng);
    chk(lng ? wr_data_o : {32'h0, wr_data_o[31:0]}, exp);
    #1;
    chk(flags_o, {4'hA, 1'b0, lng ? exp[63] : exp[31], exp == 64'h0,
                  lng ? |exp[63:32] : |exp[31:16]});
    if (op[15:14] == MODE_REG) chk(u_umu_core_model.regs[op[7:4]], sv);
    chk(rf_sizes[1:0], lng ? SIZE_QUAD : SIZE_PAIR);
    if (op[15:14] == MODE_REG) chk(rf_sizes[3:2], lng ? SIZE_PAIR : SIZE_WORD);
    else if (op[7:4] != FIELD_IMM || op[15:14] == MODE_EAM)
      chk(mem_cap, {op[15:14] == MODE_EAM, lng});
    wb(1'b0, ADR_PROD_LO, 32'h0);
    chk(rd, exp[31:0]);
    wb(1'b0, ADR_PROD_HI, 32'h0);
    chk(rd, lng ? exp[63:32] : 32'h0);
    $display("test done op=%h", op);
  endtask
  task results;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    mismatches++;
    results;
  end
  initial begin
    {cyc_i, stb_i, we_i, word_valid_i, adr_i, dat_i, word_i, lat} = '0;
    sel_i = 4'hF;
    rst_i = 1'b1;
    mismatches = 0;
    check_count = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, ADR_FLAGS, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(word_ready_o, 1'b0);
    wb(1'b1, ADR_CTRL, 32'h1);
    $display("test done registers");
    // stray word and an opcode with mode 11 must leave the decoder idle
    send(16'h1234);
    send(PREFIX_WORD);
    send({2'b11, OPC_WORD, 8'h00});
    @(posedge clk_i);
    chk(word_ready_o, 1'b1);
    $display("test done decoder");
    run({MODE_REG, OPC_WORD, 4'h5, 4'h2}, 0, 0, 64'hDEADBEEF1234FFFF,
        64'h55555555AAAAFFFF, 64'hFFFE0001);
    run({MODE_IM_IR, OPC_WORD, FIELD_IMM, 4'h0}, 1, 32'h10, 64'hABCDFFFF, 0, 64'hFFFF0);
    run({MODE_IM_IR, OPC_WORD, FIELD_IMM, 4'h4}, 1, 0, 64'h77779999, 0, 64'h0);
    run({MODE_IM_IR, OPC_WORD, FIELD_IMM, 4'h6}, 1, 32'h5, 64'hFFFF0003, 0, 64'hF);
    run({MODE_IM_IR, OPC_WORD, 4'h3, 4'hA}, 0, 0, 64'h2, 64'h5A5A8000, 64'h10000);
    // quad destinations use valid codes 4, 8 and 12
    run({MODE_REG, OPC_LONG, 4'h8, 4'h4}, 0, 0, 64'h22222222FFFFFFFF,
        64'h11111111FFFFFFFF, 64'hFFFFFFFE00000001);
    run({MODE_IM_IR, OPC_LONG, FIELD_IMM, 4'h8}, 2, 32'h10000, 64'hFFFFFFFF00001234,
        0, 64'h12340000);
    run({MODE_EAM, OPC_LONG, 4'h7, 4'hC}, 0, 0, 64'h80000000, 64'h2,
        64'h100000000);
    results;
  end
endmodule
